// ---- pkg/tcp_consts.svh ----
// Register offsets, field positions and reset values of the PWM channel pair.
`ifndef TCP_CONSTS_SVH
`define TCP_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define TCP_OFF_MASTER_MODE    12'h000
`define TCP_OFF_MASTER_CMP     12'h004
`define TCP_OFF_SLAVE_MODE     12'h008
`define TCP_OFF_SLAVE_CMP      12'h00c
`define TCP_OFF_OUT_MODE       12'h010
`define TCP_OFF_OUT_LEVEL      12'h014
`define TCP_OFF_OUT_VALUE      12'h018
`define TCP_OFF_OUT_ENABLE     12'h01c
`define TCP_OFF_START          12'h020
`define TCP_OFF_ENABLE_STAT    12'h024
`define TCP_OFF_PORT_LATCH     12'h028
`define TCP_OFF_PORT_DIR       12'h02c
`define TCP_OFF_IRQ_FLAGS      12'h030
`define TCP_OFF_IRQ_MASK       12'h034
`define TCP_OFF_COUNTERS       12'h038
`define TCP_OFF_PRESCALE       12'h03c

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define TCP_MODE_LSB           0
`define TCP_MODE_MSB           3
`define TCP_STS_LSB            8
`define TCP_STS_MSB            10
`define TCP_CIS_LSB            6
`define TCP_CIS_MSB            7
`define TCP_STS_MASTER_IRQ     3'h4
`define TCP_PWM_PIN_BIT        4
`define TCP_MASK_RESET         8'hc0
`define TCP_PORT_DIR_RESET     8'hff
`define TCP_MODE_RESET         16'h0000

`endif

// ---- pkg/tcp_pkg.sv ----
// Types shared by the PWM channel pair.
package tcp_pkg;

	typedef enum logic [2:0] {
		TCP_MD_INTERVAL  = 3'h0,
		TCP_MD_CAPTURE   = 3'h2,
		TCP_MD_EVENT     = 3'h3,
		TCP_MD_ONECOUNT  = 3'h4,
		TCP_MD_CAP_ONE   = 3'h6
	} tcp_mode_t;

	typedef enum logic [1:0] {
		TCP_EDGE_FALL = 2'h0,
		TCP_EDGE_RISE = 2'h1,
		TCP_EDGE_LOW  = 2'h2,
		TCP_EDGE_HIGH = 2'h3
	} tcp_edge_t;

endpackage

// ---- hw/tcp_pwm.sv ----
// Master and slave timer channel pair producing PWM, with an APB register file.
//
// Contract
// R1 - Mode field selects interval, capture, event, one-count or capture-one-count; others prohibited.
// R2 - Interval or capture with low bit set: interrupt and output change at start.
// R3 - One-count with low bit set: restart during counting accepted, raising interrupt; only the slave does this, the master ignores a hardware restart.
// R4 - Event and capture-one-count need low bit zero; no start interrupt, restart ignored.
// R5 - PWM uses slave in one-count, master in interval mode, pulse per period.
// R6 - Duty equals slave compare over master compare plus one, times 100.
// R7 - Output mode zero toggles on own interrupt; one sets on master, resets on slave.
// R8 - Output polarity bit zero is active high, one is active low.
// R9 - Each channel has a software output value bit.
// R10 - Output enable zero: software writes land and the pin shows them.
// R11 - Output enable one: software writes ignored, timer drives the output.
// R12 - Writing one to start trigger sets enable flag; writing zero does nothing.
// R13 - Master interrupt flag reads one while pending; software clears it.
// R14 - Interrupt mask bit zero enables, one disables interrupt.
// R15 - Pin direction zero turns output buffer on, one turns it off.
// R16 - Both-edge settings: low width starts falling; high width starts rising.
// R17 - Start trigger code for master interrupt starts slave on master interrupt.
// R18 - Period equals master compare plus one count clock periods.
// R19 - Master interrupt reloads slave counter; slave end interrupt ends the pulse.
`timescale 1ns/1ps
`include "tcp_consts.svh"

module tcp_pwm
	import tcp_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [1:0]  timer_in,
	output logic [1:0]       timer_out,
	output logic [1:0]       timer_oe,
	output logic             irq
);

	if (CNT_W < 2 || CNT_W > 16) begin
		$error("tcp_pwm: CNT_W must be 2 to 16");
	end

	// ------------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------------
	wire        acc      = psel & penable;
	wire        wr       = acc & pwrite;
	wire [11:0] a        = {paddr[11:2], 2'b00};
	wire        hit_mm   = a == `TCP_OFF_MASTER_MODE;
	wire        hit_mc   = a == `TCP_OFF_MASTER_CMP;
	wire        hit_sm   = a == `TCP_OFF_SLAVE_MODE;
	wire        hit_sc   = a == `TCP_OFF_SLAVE_CMP;
	wire        hit_om   = a == `TCP_OFF_OUT_MODE;
	wire        hit_ol   = a == `TCP_OFF_OUT_LEVEL;
	wire        hit_ov   = a == `TCP_OFF_OUT_VALUE;
	wire        hit_oe   = a == `TCP_OFF_OUT_ENABLE;
	wire        hit_st   = a == `TCP_OFF_START;
	wire        hit_es   = a == `TCP_OFF_ENABLE_STAT;
	wire        hit_pl   = a == `TCP_OFF_PORT_LATCH;
	wire        hit_pd   = a == `TCP_OFF_PORT_DIR;
	wire        hit_if   = a == `TCP_OFF_IRQ_FLAGS;
	wire        hit_mk   = a == `TCP_OFF_IRQ_MASK;
	wire        hit_cn   = a == `TCP_OFF_COUNTERS;
	wire        hit_ps   = a == `TCP_OFF_PRESCALE;
	wire        mapped   = hit_mm | hit_mc | hit_sm | hit_sc | hit_om | hit_ol | hit_ov |
		hit_oe | hit_st | hit_es | hit_pl | hit_pd | hit_if | hit_mk | hit_cn | hit_ps;
	wire        wlo      = wr & pstrb[0];
	wire        whi      = wr & pstrb[1];

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	logic [15:0]      mmode_reg, smode_reg;
	logic [CNT_W-1:0] mcmp_reg, scmp_reg, mcnt_reg, scnt_reg;
	logic [1:0]       omode_reg, olvl_reg, oval_reg, oen_reg, en_reg, run_reg;
	logic [7:0]       plat_reg, pdir_reg, iflag_reg, imask_reg;
	logic [3:0]       pre_sel_reg;
	logic [15:0]      pre_cnt_reg;
	logic [1:0]       tin_reg;

	// Prescaled count clock tick; a single shared divider keeps both channels in step.
	wire [15:0] pre_mask = 16'((17'h1 << pre_sel_reg) - 17'h1);
	wire        tick     = (pre_cnt_reg & pre_mask) == pre_mask;

	// ------------------------------------------------------------------------
	// Mode decode per channel
	// ------------------------------------------------------------------------
	wire [2:0] mm = mmode_reg[`TCP_MODE_MSB:`TCP_MODE_LSB+1];
	wire [2:0] sm = smode_reg[`TCP_MODE_MSB:`TCP_MODE_LSB+1];
	wire       m_lsb = mmode_reg[`TCP_MODE_LSB];
	wire       s_lsb = smode_reg[`TCP_MODE_LSB];
	// Prohibited codes leave the channel idle rather than guess a behaviour.
	function automatic logic legal(input logic [2:0] m, input logic lsb);
		case (m)
			TCP_MD_INTERVAL, TCP_MD_CAPTURE, TCP_MD_ONECOUNT: legal = 1'b1; // R1
			TCP_MD_EVENT, TCP_MD_CAP_ONE:                      legal = ~lsb; // R4
			default:                                           legal = 1'b0; // R1
		endcase
	endfunction
	wire m_ok = legal(mm, m_lsb);
	wire s_ok = legal(sm, s_lsb);
	wire m_up = (mm == TCP_MD_CAPTURE) | (mm == TCP_MD_CAP_ONE); // R1
	wire s_up = (sm == TCP_MD_CAPTURE) | (sm == TCP_MD_CAP_ONE); // R1

	// Timer input edge detection, with both-edge start/capture split.
	wire [1:0] rise = timer_in & ~tin_reg;
	wire [1:0] fall = ~timer_in & tin_reg;
	function automatic logic [1:0] edges(input logic [1:0] cis, input logic r, input logic f);
		case (cis)
			TCP_EDGE_FALL: edges = {f, f};
			TCP_EDGE_RISE: edges = {r, r};
			TCP_EDGE_LOW:  edges = {f, r}; // R16
			TCP_EDGE_HIGH: edges = {r, f}; // R16
			default:       edges = 2'b00;
		endcase
	endfunction
	wire [1:0] m_ed = edges(mmode_reg[`TCP_CIS_MSB:`TCP_CIS_LSB], rise[0], fall[0]);
	wire [1:0] s_ed = edges(smode_reg[`TCP_CIS_MSB:`TCP_CIS_LSB], rise[1], fall[1]);

	// ------------------------------------------------------------------------
	// Start triggers
	// ------------------------------------------------------------------------
	wire [1:0] sw_start = (wlo & hit_st) ? pwdata[1:0] : 2'b00; // R12
	logic      m_irq, s_irq;
	function automatic logic hw_trig(input logic [2:0] sts, input logic [1:0] ed, input logic mi);
		case (sts)
			3'h1:                hw_trig = ed[1];
			3'h2:                hw_trig = ed[1];
			`TCP_STS_MASTER_IRQ: hw_trig = mi; // R17
			default:             hw_trig = 1'b0;
		endcase
	endfunction
	wire m_trig = en_reg[0] & hw_trig(mmode_reg[`TCP_STS_MSB:`TCP_STS_LSB], m_ed, 1'b0);
	wire s_trig = en_reg[1] & hw_trig(smode_reg[`TCP_STS_MSB:`TCP_STS_LSB], s_ed, m_irq);

	// Master: interval counts down and reloads, so the period is compare plus one ticks.
	wire m_sw_go  = sw_start[0] & m_ok;
	wire m_zero   = mcnt_reg == '0;
	wire m_end    = run_reg[0] & tick & ~m_up & m_zero; // R18
	wire m_go     = m_sw_go | (m_trig & ~run_reg[0] & m_ok);
	wire m_st_irq = m_go & m_lsb & ((mm == TCP_MD_INTERVAL) | (mm == TCP_MD_CAPTURE)); // R2
	wire m_cap    = run_reg[0] & m_up & m_ed[0] & (mmode_reg[`TCP_STS_MSB:`TCP_STS_LSB] != 3'h0);
	assign m_irq  = m_end | m_st_irq | m_cap;

	// Slave: one-count restarts only when the low bit allows it.
	wire s_retrig = (sm == TCP_MD_ONECOUNT) & s_lsb;                         // R3
	wire s_accept = s_trig & s_ok & (~run_reg[1] | s_retrig);                // R3 R4
	wire s_go     = (sw_start[1] & s_ok) | s_accept;
	wire s_zero   = scnt_reg == '0;
	wire s_one    = sm == TCP_MD_ONECOUNT;
	// One-count ends as the count reaches zero, so the pulse lasts exactly compare ticks.
	wire s_last   = s_one ? (scnt_reg == CNT_W'(1)) : s_zero;                // R6
	// A zero compare ends the pulse at once, giving no active time at all.
	wire s_empty  = s_accept & s_one & (scmp_reg == '0);                     // R6
	wire s_end    = (run_reg[1] & tick & ~s_up & s_last & ~s_accept) | s_empty; // R19
	wire s_st_irq = (s_go & s_lsb & ((sm == TCP_MD_INTERVAL) | (sm == TCP_MD_CAPTURE))) |
		(s_accept & run_reg[1] & s_retrig);                                  // R2 R3
	wire s_cap    = run_reg[1] & s_up & s_ed[0] & (smode_reg[`TCP_STS_MSB:`TCP_STS_LSB] != 3'h0);
	assign s_irq  = s_end | s_st_irq | s_cap;

	// ------------------------------------------------------------------------
	// Counters
	// ------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mcnt_reg    <= '0;
			scnt_reg    <= '0;
			run_reg     <= 2'b00;
			en_reg      <= 2'b00;
			pre_cnt_reg <= 16'h0000;
			tin_reg     <= 2'b00;
		end else begin
			pre_cnt_reg <= tick ? 16'h0000 : pre_cnt_reg + 16'h0001;
			tin_reg     <= timer_in;
			en_reg      <= en_reg | sw_start; // R12
			if (m_go)
				mcnt_reg <= m_up ? '0 : mcmp_reg;
			else if (m_end)
				mcnt_reg <= mcmp_reg; // R5
			else if (run_reg[0] & tick)
				mcnt_reg <= m_up ? mcnt_reg + 1'b1 : mcnt_reg - 1'b1;
			if (m_go)
				run_reg[0] <= 1'b1;
			else if (m_end & (mm != TCP_MD_INTERVAL))
				run_reg[0] <= 1'b0;
			// Slave reloads on each accepted trigger and stops at its end, except in interval mode, where it reloads and keeps running.
			if (s_go)
				scnt_reg <= s_up ? '0 : scmp_reg; // R19
			else if (run_reg[1] & tick & ~(s_end & s_zero))
				scnt_reg <= s_up ? scnt_reg + 1'b1 : scnt_reg - 1'b1;
			if (s_go & ~s_empty)
				run_reg[1] <= 1'b1;
			else if (s_end & (sm != TCP_MD_INTERVAL))
				run_reg[1] <= 1'b0; // R5
			else if (s_end)
				scnt_reg <= scmp_reg;
		end
	end

	// ------------------------------------------------------------------------
	// Output logic
	// ------------------------------------------------------------------------
	// Timer-driven output level per channel before polarity.
	logic [1:0] tout;
	always_comb begin
		tout = oval_reg;
		if (omode_reg[0] ? 1'b0 : m_irq)
			tout[0] = ~oval_reg[0]; // R7
		if (omode_reg[1]) begin
			if (s_irq)
				tout[1] = 1'b0; // R7 R19
			else if (m_irq)
				tout[1] = 1'b1; // R7
		end else if (s_irq)
			tout[1] = ~oval_reg[1]; // R7
	end
	wire [1:0] sw_val = (wlo & hit_ov) ? pwdata[1:0] : oval_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			oval_reg <= 2'b00;
		else begin
			for (int i = 0; i < 2; i++)
				oval_reg[i] <= oen_reg[i] ? tout[i] : sw_val[i]; // R10 R11 R9
		end
	end

	// Polarity is applied at the pin so the stored value keeps its timer meaning.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_out <= 2'b00;
			timer_oe  <= 2'b00;
		end else begin
			timer_out <= oval_reg ^ olvl_reg; // R8
			timer_oe  <= {~pdir_reg[`TCP_PWM_PIN_BIT], 1'b0}; // R15
		end
	end

	// ------------------------------------------------------------------------
	// Interrupt flags and mask
	// ------------------------------------------------------------------------
	wire [7:0] ev      = {s_irq, m_irq, 6'h00};
	wire [7:0] if_clr  = (wlo & hit_if) ? pwdata[7:0] : 8'h00;
	assign irq = |(iflag_reg & ~imask_reg); // R14

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			iflag_reg <= 8'h00;
		else
			iflag_reg <= (iflag_reg & ~if_clr) | ev; // R13
	end

	// ------------------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mmode_reg   <= `TCP_MODE_RESET;
			smode_reg   <= `TCP_MODE_RESET;
			mcmp_reg    <= '0;
			scmp_reg    <= '0;
			omode_reg   <= 2'b00;
			olvl_reg    <= 2'b00;
			oen_reg     <= 2'b00;
			plat_reg    <= 8'h00;
			pdir_reg    <= `TCP_PORT_DIR_RESET;
			imask_reg   <= `TCP_MASK_RESET;
			pre_sel_reg <= 4'h0;
		end else begin
			if (wlo & hit_mm) mmode_reg[7:0]  <= pwdata[7:0];
			if (whi & hit_mm) mmode_reg[15:8] <= pwdata[15:8];
			if (wlo & hit_sm) smode_reg[7:0]  <= pwdata[7:0];
			if (whi & hit_sm) smode_reg[15:8] <= pwdata[15:8];
			if (wr & hit_mc) mcmp_reg <= pwdata[CNT_W-1:0];
			if (wr & hit_sc) scmp_reg <= pwdata[CNT_W-1:0]; // R6
			if (wlo & hit_om) omode_reg <= pwdata[1:0];
			if (wlo & hit_ol) olvl_reg  <= pwdata[1:0];
			if (wlo & hit_oe) oen_reg   <= pwdata[1:0];
			if (wlo & hit_pl) plat_reg  <= pwdata[7:0];
			if (wlo & hit_pd) pdir_reg  <= pwdata[7:0];
			if (wlo & hit_mk) imask_reg <= pwdata[7:0];
			if (wlo & hit_ps) pre_sel_reg <= pwdata[3:0];
		end
	end

	// ------------------------------------------------------------------------
	// Read back
	// ------------------------------------------------------------------------
	logic [31:0] rd;
	always_comb begin
		rd = 32'h0000_0000;
		case (1'b1)
			hit_mm: rd[15:0] = mmode_reg;
			hit_mc: rd[CNT_W-1:0] = mcmp_reg;
			hit_sm: rd[15:0] = smode_reg;
			hit_sc: rd[CNT_W-1:0] = scmp_reg;
			hit_om: rd[1:0] = omode_reg;
			hit_ol: rd[1:0] = olvl_reg;
			hit_ov: rd[1:0] = oval_reg;
			hit_oe: rd[1:0] = oen_reg;
			hit_es: rd[3:0] = {run_reg, en_reg};
			hit_pl: rd[7:0] = plat_reg;
			hit_pd: rd[7:0] = pdir_reg;
			hit_if: rd[7:0] = iflag_reg;
			hit_mk: rd[7:0] = imask_reg;
			hit_cn: rd = {16'(scnt_reg), 16'(mcnt_reg)};
			hit_ps: rd[3:0] = pre_sel_reg;
			default: rd = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel & ~penable & ~pwrite)
			prdata <= rd;
	end

	assign pready  = 1'b1;
	assign pslverr = acc & ~mapped;

endmodule

// ---- tb/tcp_pwm_chk.sv ----
// Port-level checker for the PWM channel pair.
`timescale 1ns/1ps
module tcp_pwm_chk
	import tcp_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [1:0]  timer_in,
	input wire logic [1:0]  timer_out,
	input wire logic [1:0]  timer_oe,
	input wire logic        irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup; psel && !penable; endsequence
	sequence s_access; psel && penable; endsequence
	property p_ready; s_setup ##1 s_access |-> pready; endproperty
	property p_map_err; (s_access and (paddr[11:2] > 10'h00f)) |-> pslverr; endproperty
	property p_map_ok; (s_access and (paddr[11:2] <= 10'h00f)) |-> !pslverr; endproperty
	property p_rd_zero;
		(s_setup and (!pwrite && (paddr[11:2] == 10'h008 || paddr[11:2] > 10'h00f)))
			|=> prdata == 32'h0;
	endproperty
	property p_masked;
		s_setup ##1 (s_access and (pwrite && paddr[11:2] == 10'h00d && pwdata[7:6] == 2'h3))
			|=> !irq [*2];
	endproperty
	property p_dir_on;
		(s_access and (pwrite && paddr[11:2] == 10'h00b && !pwdata[4])) |-> ##[1:3] timer_oe[1];
	endproperty
	property p_oe0; timer_oe[0] == 1'b0; endproperty
	property p_reset; $rose(presetn) |-> !irq && timer_oe == 2'h0 && timer_out == 2'h0; endproperty
	a_ready: assert property (p_ready) else $error("access phase without ready");
	a_map_err: assert property (p_map_err) else $error("unmapped access not flagged");
	a_map_ok: assert property (p_map_ok) else $error("mapped access flagged");
	a_rd_zero: assert property (p_rd_zero) else $error("read data not zero");
	a_masked: assert property (p_masked) else $error("interrupt while fully masked");
	a_dir_on: assert property (p_dir_on) else $error("pin buffer not on");
	a_oe0: assert property (p_oe0) else $error("channel zero buffer on");
	a_reset: assert property (p_reset) else $error("outputs not idle after reset");
endmodule
bind tcp_pwm tcp_pwm_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .timer_in(timer_in), .timer_out(timer_out),
	.timer_oe(timer_oe), .irq(irq));

// ---- tb/tcp_load_model.sv ----
// Load on the PWM pin: pull-up when undriven, counts cycles spent high.
`timescale 1ns/1ps
module tcp_load_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clr,
	input  wire logic        drive,
	input  wire logic        oe,
	output logic             pin,
	output logic [15:0]      high_cnt
);
	// The pull-up keeps an undriven pin from reading as a stale level.
	assign pin = oe ? drive : 1'b1;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			high_cnt <= 16'h0;
		else if (clr)
			high_cnt <= 16'h0;
		else
			high_cnt <= high_cnt + {15'h0, pin};
	end
endmodule

// ---- tb/timer_channel_pair_pwm_test.sv ----
// Self-checking testbench for the PWM channel pair.
`timescale 1ns/1ps
module timer_channel_pair_pwm_test
	import tcp_pkg::*;
;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'hf;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [1:0]  timer_out;
	logic [1:0]  timer_oe;
	logic        irq;
	logic        clr = 1'b0;
	logic        pin;
	logic [15:0] high_cnt;
	logic [31:0] rd;
	logic        err;
	int          mismatches = 0;
	int          comparisons = 0;
	always #5 pclk = ~pclk;
	tcp_pwm i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timer_in({pin, timer_out[0]}),
		.timer_out(timer_out), .timer_oe(timer_oe), .irq(irq));
	tcp_load_model i_load (.pclk(pclk), .presetn(presetn), .clr(clr), .drive(timer_out[1]),
		.oe(timer_oe[1]), .pin(pin), .high_cnt(high_cnt));
	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	task duty(input logic [15:0] exp);
		cyc(40);
		@(posedge pclk);
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
		cyc(100);
		chk("high cycles", {16'h0, high_cnt}, {16'h0, exp});
	endtask
	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task test_reset_map;
		xfer(1'b0, 12'h034, 32'h0);
		chk("mask reset", rd, 32'hc0);
		xfer(1'b0, 12'h02c, 32'h0);
		chk("dir reset", rd, 32'hff);
		xfer(1'b0, 12'h030, 32'h0);
		chk("flags reset", rd, 32'h0);
		xfer(1'b0, 12'h040, 32'h0);
		chk("unmapped err", {31'h0, err}, 32'h1);
		chk("buffer off", {30'h0, timer_oe}, 32'h0);
	endtask
	task test_sw_output;
		xfer(1'b1, 12'h02c, 32'hef);
		xfer(1'b1, 12'h018, 32'h2);
		cyc(3);
		chk("pin sw high", {31'h0, pin}, 32'h1);
		xfer(1'b1, 12'h014, 32'h2);
		cyc(3);
		chk("pin inverted", {31'h0, timer_out[1]}, 32'h0);
		xfer(1'b1, 12'h014, 32'h0);
		xfer(1'b1, 12'h01c, 32'h2);
		xfer(1'b1, 12'h018, 32'h0);
		xfer(1'b0, 12'h018, 32'h0);
		chk("value locked", rd, 32'h2);
	endtask
	task test_pwm;
		// Period of ten ticks, duty of three, no prescale.
		xfer(1'b1, 12'h000, 32'h0000);
		xfer(1'b1, 12'h004, 32'h9);
		xfer(1'b1, 12'h008, 32'h0409);
		xfer(1'b1, 12'h00c, 32'h3);
		xfer(1'b1, 12'h010, 32'h2);
		xfer(1'b1, 12'h03c, 32'h0);
		xfer(1'b1, 12'h020, 32'h3);
		xfer(1'b0, 12'h024, 32'h0);
		chk("enable flags", {30'h0, rd[1:0]}, 32'h3);
		duty(16'd30);
		xfer(1'b1, 12'h014, 32'h2);
		duty(16'd70);
	endtask
	task test_irq;
		xfer(1'b0, 12'h030, 32'h0);
		chk("master flag", {31'h0, rd[6]}, 32'h1);
		chk("irq masked", {31'h0, irq}, 32'h0);
		xfer(1'b1, 12'h034, 32'h80);
		cyc(1);
		chk("irq unmasked", {31'h0, irq}, 32'h1);
		xfer(1'b1, 12'h034, 32'hc0);
		cyc(1);
		chk("irq remasked", {31'h0, irq}, 32'h0);
		// A long period leaves a quiet stretch in which the clear cannot race a new event.
		xfer(1'b1, 12'h004, 32'hffff);
		cyc(20);
		xfer(1'b1, 12'h030, 32'hc0);
		xfer(1'b0, 12'h030, 32'h0);
		chk("flags cleared", rd, 32'h0);
	endtask
	task test_done;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		test_reset_map();
		test_sw_output();
		test_pwm();
		test_irq();
		test_done();
	end
	// The whole run needs well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge pclk);
		mismatches++;
		test_done();
	end
endmodule
